// file: sim/fic_fdc_model.sv
// Behavioural disk controller: four registers, request lines set by the bench
module fic_fdc_model
(
  input wire logic refClk,
  input wire logic [1:0] fdcAddr,
  input wire logic fdcSelN,
  input wire logic fdcWriteN,
  input wire logic [7:0] fdcWdata,
  output logic [7:0] fdcRdata,
  input wire logic raiseDrq,
  input wire logic raiseDone,
  output logic dataRequestIn = 1'b0,
  output logic cmdCompleteIn = 1'b0
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] regFile [4];
  logic [7:0] lastRd = 8'h00;
  // Register writes and request clearing on access
  always_ff @(posedge refClk)
  begin
    if (!fdcSelN && !fdcWriteN) regFile[fdcAddr] <= fdcWdata;
    if (!fdcSelN) lastRd <= fdcRdata;
    if (raiseDrq) dataRequestIn <= 1'b1;
    else if (!fdcSelN && fdcAddr == 2'h3) dataRequestIn <= 1'b0;
    if (raiseDone) cmdCompleteIn <= 1'b1;
    else if (!fdcSelN && fdcAddr == 2'h0) cmdCompleteIn <= 1'b0;
  end
  // Idle bus shows inverted stale data so a missed select cannot pass
  assign fdcRdata = fdcSelN ? ~lastRd : (fdcAddr == 2'h0 ? 8'h04 : regFile[fdcAddr]);
endmodule : fic_fdc_model

// file: sim/tb_fic_floppy_glue.sv
module tb_fic_floppy_glue;
  timeunit 1ns;
  timeprecision 1ns;
  logic refClk = 1'b0;
  logic nrst = 1'b0;
  logic softResetN = 1'b1;
  logic [23:0] cpuAddr = 24'h000000;
  logic cpuSel = 1'b0;
  logic cpuWrite = 1'b0;
  logic [7:0] cpuWdata = 8'h00;
  logic [7:0] cpuRdata, fdcWdata, fdcRdata, rd;
  logic [7:0] shadow = 8'h00;
  logic cpuAck, fdcSelN, fdcWriteN, dataRequestIn, cmdCompleteIn, doubleRateEnableInN;
  logic motorOn, sideSelect, sideLedOn, unit0Select, unit1Select, irqLevel5, irqLevel7;
  logic [1:0] fdcAddr;
  logic spindleRequestOut = 1'b0;
  logic driveReadyN = 1'b0;
  logic noReadyOption = 1'b0;
  logic raiseDrq = 1'b0;
  logic raiseDone = 1'b0;
  logic [4:0] senseSwitch = 5'h15;
  wire logic [7:0] pins = {motorOn, sideSelect, sideLedOn, doubleRateEnableInN,
    unit1Select, unit0Select, irqLevel5, irqLevel7};
  int bad_count = 0;
  int total_checks = 0;
  fic_floppy_glue fic_floppy_glue_inst (.*);
  fic_fdc_model fic_fdc_model_inst (.*);
  // Clock, 100 ns period
  initial
  begin
    forever #50 refClk = ~refClk;
  end
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp) $display("Error %0t: got %h expected %h", $time, got, exp);
    if (got !== exp) bad_count++;
  endtask : chk
  // One bus access; read data is registered, so it is taken an edge later
  task automatic acc(input logic w, input logic [23:0] a, input logic [7:0] d);
    @(posedge refClk);
    cpuSel <= 1'b1;
    cpuWrite <= w;
    cpuAddr <= a;
    cpuWdata <= d;
    #1 chk({7'h00, cpuAck}, 8'h01);
    if (w && a == 24'hff8004) shadow = d;
    @(posedge refClk);
    cpuSel <= 1'b0;
    #1 rd = cpuRdata;
  endtask : acc
  // Let asynchronous inputs cross the synchroniser
  task automatic settle();
    repeat (6) @(posedge refClk);
    #1;
  endtask : settle
  task automatic t_reset();
    acc(1'b0, 24'hff8000, 8'h00);
    chk(rd, 8'h04);
    chk(pins, 8'h20);
    acc(1'b0, 24'hff8004, 8'h00);
    chk(rd, 8'h35);
    acc(1'b1, 24'hff8005, 8'hff);
    chk(pins, 8'h20);
    acc(1'b0, 24'hff8005, 8'h00);
    chk(rd, 8'h00);
  endtask : t_reset
  task automatic t_fdc();
    for (int i = 1; i < 4; i++) acc(1'b1, 24'hff8000 + 24'(i), 8'h50 + 8'(i));
    for (int i = 1; i < 4; i++)
    begin
      acc(1'b0, 24'hff8000 + 24'(i), 8'h00);
      chk(rd, 8'h50 + 8'(i));
    end
    acc(1'b0, 24'hff8000, 8'h00);
    chk(rd, 8'h04);
  endtask : t_fdc
  task automatic t_ctrl();
    acc(1'b1, 24'hff8004, 8'h1d);
    chk(pins, 8'hd4);
    settle();
    acc(1'b0, 24'hff8004, 8'h00);
    chk(rd, 8'h15);
    spindleRequestOut <= 1'b1;
    acc(1'b1, 24'hff8004, 8'h02);
    settle();
    chk(pins, 8'ha8);
    spindleRequestOut <= 1'b0;
    settle();
    chk(pins, 8'h20);
    acc(1'b0, 24'hff8004, 8'h00);
    chk(rd, 8'h35);
    noReadyOption <= 1'b1;
    settle();
    acc(1'b0, 24'hff8004, 8'h00);
    chk(rd, 8'h15);
    noReadyOption <= 1'b0;
  endtask : t_ctrl
  // Pulse one request line of the controller model
  task automatic kick(input logic data_request_flag);
    @(posedge refClk);
    raiseDrq <= data_request_flag;
    raiseDone <= !data_request_flag;
    @(posedge refClk);
    raiseDrq <= 1'b0;
    raiseDone <= 1'b0;
    settle();
  endtask : kick
  task automatic t_irq();
    acc(1'b1, 24'hff8004, 8'h80);
    kick(1'b1);
    chk(pins, {7'h10, shadow[7]});
    acc(1'b0, 24'hff8003, 8'h00);
    settle();
    chk(pins, 8'h20);
    acc(1'b1, 24'hff8004, 8'h00);
    kick(1'b1);
    chk(pins, 8'h20);
    acc(1'b0, 24'hff8004, 8'h00);
    chk(rd, 8'hb5);
    acc(1'b1, 24'hff8003, 8'h00);
    kick(1'b0);
    chk(pins, 8'h22);
    acc(1'b0, 24'hff8004, 8'h00);
    chk(rd, 8'h75);
    acc(1'b1, 24'hff8000, 8'h00);
    settle();
    chk(pins, 8'h20);
  endtask : t_irq
  task automatic t_soft();
    acc(1'b1, 24'hff8004, 8'h1d);
    softResetN <= 1'b0;
    @(posedge refClk);
    softResetN <= 1'b1;
    #1 chk(pins, 8'h20);
  endtask : t_soft
  task automatic test_done();
    if (bad_count == 0 && total_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : test_done
  // Main sequence after ten reset cycles
  initial
  begin
    repeat (10) @(posedge refClk);
    nrst <= 1'b1;
    settle();
    t_reset();
    t_fdc();
    t_ctrl();
    t_irq();
    t_soft();
    test_done();
  end
  // Watchdog, well past the 125 or so cycles the tests need
  initial
  begin
    repeat (5000) @(posedge refClk);
    bad_count++;
    test_done();
  end
endmodule : tb_fic_floppy_glue

// file: verilog/fic_floppy_glue.sv
// Notes on behaviour
// - Four consecutive byte addresses from base reach the disk controller's registers.
// - Base: read status, write command; then track, sector, data read/write.
// - Board register is 8 bits; reads never return written values.
// - Write-only board bits clear on hardware reset and software system reset.
// - Read bit 7 mirrors the controller data request line.
// - Read bit 6 mirrors the controller command-done request.
// - Command-done always raises level 5 interrupt, removed when request clears.
// - Read bit 5 low when selected drive ready; option forces low.
// - Write bit 7 enables the level 7 interrupt only, not the flag.
// - Level 7 interrupt only while data request high and enable set.
// - Write bit 4 ORed with controller motor request drives motor line.
// - Write bit 3 picks side; indicator lit while bit is zero.
// - Write bit 2 drives controller density input directly; zero means double.
// - Write bits 1 and 0 select drive 1 and drive 0.
// - Density bit gives FM at lower rate or MFM at higher rate.
// - Each drive select out asserts only with its bit and motor on.
module fic_floppy_glue
(
  input wire logic refClk,
  input wire logic nrst,
  input wire logic softResetN,
  input wire logic [23:0] cpuAddr,
  input wire logic cpuSel,
  input wire logic cpuWrite,
  input wire logic [7:0] cpuWdata,
  output logic [7:0] cpuRdata,
  output logic cpuAck,
  output logic [1:0] fdcAddr,
  output logic fdcSelN,
  output logic fdcWriteN,
  output logic [7:0] fdcWdata,
  input wire logic [7:0] fdcRdata,
  input wire logic dataRequestIn,
  input wire logic cmdCompleteIn,
  input wire logic spindleRequestOut,
  output logic doubleRateEnableInN,
  input wire logic driveReadyN,
  input wire logic noReadyOption,
  input wire logic [4:0] senseSwitch,
  output logic motorOn,
  output logic sideSelect,
  output logic sideLedOn,
  output logic unit0Select,
  output logic unit1Select,
  output logic irqLevel5,
  output logic irqLevel7
);

  logic [7:0] ctrl_r;
  logic [2:0] drqSync_r;
  logic [2:0] intSync_r;
  logic [2:0] rdySync_r;
  logic [2:0] moSync_r;
  logic dataRequestFlag_r;
  logic cmdCompleteReq_r;
  logic driveRdyN_r;
  logic spindleReq_r;
  logic [7:0] cpuRdata_nxt;
  logic hitFdc;
  logic hitBoard;
  logic combinedMotor;

  // Address decode: controller window is four bytes, board register one
  assign hitFdc = cpuSel && (cpuAddr[23:2] == fic_pkg::ADDR_STATUS_COMMAND[23:2]);
  assign hitBoard = cpuSel && (cpuAddr == fic_pkg::ADDR_BOARD_CTRL);

  // Controller strobes pass straight through; low two bits pick the register
  assign fdcAddr = cpuAddr[1:0];
  assign fdcSelN = ~hitFdc;
  assign fdcWriteN = ~(hitFdc && cpuWrite);
  assign fdcWdata = cpuWdata;
  assign cpuAck = cpuSel;

  // Write-only control bits; either reset source clears them
  always_ff @(posedge refClk or negedge nrst)
  begin
    if (!nrst)
      ctrl_r <= fic_pkg::CTRL_RESET;
    else if (!softResetN)
      ctrl_r <= fic_pkg::CTRL_RESET;
    else if (hitBoard && cpuWrite)
      ctrl_r <= cpuWdata;
  end

  // Pin synchronisers; a change counts when the last two stages agree
  always_ff @(posedge refClk or negedge nrst)
  begin
    if (!nrst)
    begin
      drqSync_r <= 3'h0;
      intSync_r <= 3'h0;
      rdySync_r <= 3'h7;
      moSync_r <= 3'h0;
    end
    else
    begin
      drqSync_r <= {drqSync_r[1:0], dataRequestIn};
      intSync_r <= {intSync_r[1:0], cmdCompleteIn};
      rdySync_r <= {rdySync_r[1:0], driveReadyN};
      moSync_r <= {moSync_r[1:0], spindleRequestOut};
    end
  end

  // Filtered copies of the controller and drive lines
  always_ff @(posedge refClk or negedge nrst)
  begin
    if (!nrst)
    begin
      dataRequestFlag_r <= 1'b0;
      cmdCompleteReq_r <= 1'b0;
      driveRdyN_r <= 1'b1;
      spindleReq_r <= 1'b0;
    end
    else
    begin
      if (drqSync_r[2] == drqSync_r[1])
        dataRequestFlag_r <= drqSync_r[2];
      if (intSync_r[2] == intSync_r[1])
        cmdCompleteReq_r <= intSync_r[2];
      if (rdySync_r[2] == rdySync_r[1])
        driveRdyN_r <= rdySync_r[2];
      if (moSync_r[2] == moSync_r[1])
        spindleReq_r <= moSync_r[2];
    end
  end

  // Drive and controller control lines
  assign combinedMotor = ctrl_r[fic_pkg::BIT_MOTOR] | spindleReq_r;
  assign motorOn = combinedMotor;
  assign unit0Select = ctrl_r[fic_pkg::BIT_UNIT0] & combinedMotor;
  assign unit1Select = ctrl_r[fic_pkg::BIT_UNIT1] & combinedMotor;
  assign sideSelect = ctrl_r[fic_pkg::BIT_SIDE];
  assign sideLedOn = ~ctrl_r[fic_pkg::BIT_SIDE];
  // Bit high means single density FM; the controller input is active low
  assign doubleRateEnableInN = ctrl_r[fic_pkg::BIT_DENSITY];

  // Interrupts: level 5 cannot be masked, level 7 is gated by the enable
  assign irqLevel5 = cmdCompleteReq_r;
  assign irqLevel7 = dataRequestFlag_r & ctrl_r[fic_pkg::BIT_XFER_IRQ_EN];

  // Read mux; the board register returns live status, never ctrl_r
  always_comb
  begin
    cpuRdata_nxt = 8'h00;
    if (hitFdc)
      cpuRdata_nxt = fdcRdata;
    else if (hitBoard)
    begin
      cpuRdata_nxt[fic_pkg::BIT_DATA_REQ] = dataRequestFlag_r;
      cpuRdata_nxt[fic_pkg::BIT_CMD_DONE] = cmdCompleteReq_r;
      // Ready is only meaningful with a drive selected and spinning
      cpuRdata_nxt[fic_pkg::BIT_DRIVE_OK] = noReadyOption ? 1'b0 :
        ~((unit0Select | unit1Select) & ~driveRdyN_r);
      cpuRdata_nxt[4:0] = senseSwitch;
    end
  end

  // Read data held in a flop so the bus sees a stable byte
  always_ff @(posedge refClk or negedge nrst)
  begin
    if (!nrst)
      cpuRdata <= 8'h00;
    else
      cpuRdata <= cpuRdata_nxt;
  end

  default clocking @(posedge refClk); endclocking
  default disable iff (!nrst);

  irq7_gate_a: assert property (irqLevel7 |-> dataRequestFlag_r && ctrl_r[7])
    else $error("level 7 raised without request and enable");
  irq5_follow_a: assert property (irqLevel5 == cmdCompleteReq_r)
    else $error("level 5 does not track command done");
  motor_or_a: assert property ((ctrl_r[4] || spindleReq_r) |-> motorOn)
    else $error("motor line low while requested");
  sel_qual_a: assert property ((unit0Select || unit1Select) |-> motorOn)
    else $error("drive selected without motor");
  soft_clear_a: assert property (!softResetN |=> ctrl_r == 8'h00)
    else $error("soft reset left control bits set");
  ctrl_write_a: assert property (hitBoard && cpuWrite && softResetN |=> ctrl_r == $past(cpuWdata))
    else $error("board write not stored");
  led_side_a: assert property (sideLedOn != sideSelect)
    else $error("indicator not inverse of side");
  recording_format_sel_pin_a: assert property (doubleRateEnableInN == ctrl_r[2])
    else $error("density pin mismatch");
  drq_flag_a: assert property (hitBoard && !cpuWrite |=> cpuRdata[7] == $past(dataRequestFlag_r))
    else $error("read bit 7 wrong");
  rdy_opt_a: assert property (hitBoard && noReadyOption |=> !cpuRdata[5])
    else $error("ready option not forcing zero");
  fdc_dec_a: assert property (cpuSel && cpuAddr == 24'hff8003 |-> !fdcSelN && fdcAddr == 2'h3)
    else $error("data register decode wrong");

  cov_irq7_c: cover property (irqLevel7);
  cov_irq5_c: cover property (irqLevel5 ##1 !irqLevel5);
  cov_board_wr_c: cover property (hitBoard && cpuWrite);
  cov_select_c: cover property (unit0Select ##1 !motorOn);
  // Software reset pulse seen and released
  cov_soft_c: cover property (!softResetN ##1 softResetN);

  // Controller window decode and strobes
  // Acknowledge is immediate, so no access ever stalls
  ack_follow_a: assert property (cpuAck == cpuSel)
    else $error("acknowledge does not follow select");
  // An idle bus must never strobe the controller
  fdc_idle_a: assert property (!cpuSel |-> fdcSelN && fdcWriteN)
    else $error("controller strobed while idle");
  // The board register lies outside the controller window
  board_excl_a: assert property (hitBoard |-> fdcSelN)
    else $error("board access reached the controller");
  // Low address bits pick the controller register
  fdc_range_a: assert property (hitFdc |-> !fdcSelN && fdcAddr == cpuAddr[1:0])
    else $error("controller window decode wrong");
  // Base address write issues a command
  cmd_write_a: assert property (cpuSel && cpuWrite &&
    cpuAddr == fic_pkg::ADDR_STATUS_COMMAND |-> !fdcWriteN && fdcAddr == 2'h0)
    else $error("command write not strobed");
  // Track register write
  track_write_a: assert property (cpuSel && cpuWrite &&
    cpuAddr == fic_pkg::ADDR_TRACK |-> !fdcWriteN && fdcAddr == 2'h1)
    else $error("track write not strobed");
  // Sector register write
  sector_write_a: assert property (cpuSel && cpuWrite &&
    cpuAddr == fic_pkg::ADDR_SECTOR |-> !fdcWriteN && fdcAddr == 2'h2)
    else $error("sector write not strobed");
  // Data register write
  data_write_a: assert property (cpuSel && cpuWrite &&
    cpuAddr == fic_pkg::ADDR_DATA |-> !fdcWriteN && fdcAddr == 2'h3)
    else $error("data write not strobed");
  // A read must not disturb controller registers
  fdc_read_a: assert property (hitFdc && !cpuWrite |-> fdcWriteN)
    else $error("write strobe on a controller read");
  // Write data passes unchanged to the controller
  fdc_wdata_a: assert property (fdcWdata == cpuWdata)
    else $error("controller write data differs");

  // Read data path
  // Controller bytes come back one edge later
  fdc_rdata_a: assert property (hitFdc |=> cpuRdata == $past(fdcRdata))
    else $error("controller read byte lost");
  // Sense switches fill the low board bits
  sense_bits_a: assert property (hitBoard |=> cpuRdata[4:0] == $past(senseSwitch))
    else $error("sense bits wrong");
  // Command-done flag on read bit 6
  done_bit_a: assert property (hitBoard |=> cpuRdata[6] == $past(cmdCompleteReq_r))
    else $error("read bit 6 wrong");
  // Unmapped selects read as zero
  unmapped_rd_a: assert property (cpuSel && !hitFdc && !hitBoard |=> cpuRdata == 8'h00)
    else $error("unmapped read not zero");
  // Idle bus returns zero, never the control bits
  idle_rdata_a: assert property (!cpuSel |=> cpuRdata == 8'h00)
    else $error("idle read data not zero");
  // Selected ready drive reads as ready
  rdy_sel_a: assert property (hitBoard && !noReadyOption &&
    (unit0Select || unit1Select) && !driveRdyN_r |=> !cpuRdata[5])
    else $error("ready drive reads not ready");
  // No drive selected reads as not ready
  rdy_idle_a: assert property (hitBoard && !noReadyOption &&
    !unit0Select && !unit1Select |=> cpuRdata[5])
    else $error("unselected drive reads ready");

  // Control register storage
  // Outside soft reset, only a board write may change the control bits
  ctrl_hold_a: assert property (softResetN && !(hitBoard && cpuWrite)
    |=> ctrl_r == $past(ctrl_r))
    else $error("control bits changed without a write");
  // Soft reset wins over a simultaneous write
  soft_win_a: assert property (!softResetN && hitBoard && cpuWrite |=> ctrl_r == 8'h00)
    else $error("write beat soft reset");

  // Synchroniser filters: a flag moves only when two stages agree
  // Data request follows agreeing stages
  drq_agree_a: assert property (drqSync_r[2] == drqSync_r[1]
    |=> dataRequestFlag_r == $past(drqSync_r[2]))
    else $error("data request filter wrong");
  // Disagreeing stages hold the data request
  drq_hold_a: assert property (drqSync_r[2] != drqSync_r[1] |=> $stable(dataRequestFlag_r))
    else $error("data request moved on a glitch");
  // Command done follows agreeing stages
  int_agree_a: assert property (intSync_r[2] == intSync_r[1]
    |=> cmdCompleteReq_r == $past(intSync_r[2]))
    else $error("command done filter wrong");
  // Disagreeing stages hold command done
  int_hold_a: assert property (intSync_r[2] != intSync_r[1] |=> $stable(cmdCompleteReq_r))
    else $error("command done moved on a glitch");
  // Drive ready follows agreeing stages
  rdy_agree_a: assert property (rdySync_r[2] == rdySync_r[1]
    |=> driveRdyN_r == $past(rdySync_r[2]))
    else $error("ready filter wrong");
  // Spindle request follows agreeing stages
  spin_agree_a: assert property (moSync_r[2] == moSync_r[1]
    |=> spindleReq_r == $past(moSync_r[2]))
    else $error("spindle filter wrong");

  // Drive cable and interrupt outputs
  // Both motor sources low stops the motors
  motor_off_a: assert property (!ctrl_r[4] && !spindleReq_r |-> !motorOn)
    else $error("motor on with no request");
  // Drive 0 select qualified by motor
  unit0_qual_a: assert property (unit0Select == (ctrl_r[0] && motorOn))
    else $error("drive 0 select wrong");
  // Drive 1 select qualified by motor
  unit1_qual_a: assert property (unit1Select == (ctrl_r[1] && motorOn))
    else $error("drive 1 select wrong");
  // Side line follows the side bit
  side_pin_a: assert property (sideSelect == ctrl_r[3])
    else $error("side line wrong");
  // Enabled data request must interrupt
  irq7_set_a: assert property (dataRequestFlag_r && ctrl_r[7] |-> irqLevel7)
    else $error("level 7 missing");
  // Cleared enable silences level 7
  irq7_mask_a: assert property (!ctrl_r[7] |-> !irqLevel7)
    else $error("level 7 raised while disabled");

endmodule : fic_floppy_glue

// file: verilog/fic_pkg.sv
package fic_pkg;
  // Byte addresses seen by the processor
  localparam logic [23:0] ADDR_STATUS_COMMAND = 24'hff8000;
  localparam logic [23:0] ADDR_TRACK = 24'hff8001;
  localparam logic [23:0] ADDR_SECTOR = 24'hff8002;
  localparam logic [23:0] ADDR_DATA = 24'hff8003;
  localparam logic [23:0] ADDR_BOARD_CTRL = 24'hff8004;
  // Field positions in board_control_status
  localparam int BIT_XFER_IRQ_EN = 7;
  localparam int BIT_DATA_REQ = 7;
  localparam int BIT_CMD_DONE = 6;
  localparam int BIT_DRIVE_OK = 5;
  localparam int BIT_MOTOR = 4;
  localparam int BIT_SIDE = 3;
  localparam int BIT_DENSITY = 2;
  localparam int BIT_UNIT1 = 1;
  localparam int BIT_UNIT0 = 0;
  // Reset value of the write-only control bits
  localparam logic [7:0] CTRL_RESET = 8'h00;
  // Data rates selected by the density bit, in bits per second
  localparam int RATE_FM_BPS = 125000;
  localparam int RATE_MFM_BPS = 250000;
endpackage : fic_pkg
